// ### fsg_pkg.sv
// Constants and types shared by the flash security access guard.
package fsg_pkg;
   localparam int          ADDR_W         = 15;
   localparam int          PAGE_W         = 5;
   localparam int          PAGE_BITS      = 10;
   localparam logic [14:0] LOCK_BYTE_ADDR = 15'h7BFF;
   localparam logic [4:0]  LOCK_PAGE      = 5'h1E;
   localparam logic [14:0] RSV_LO         = 15'h7C00;
   localparam logic [14:0] RSV_HI         = 15'h7FFF;
   localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
   localparam logic [7:0]  NONE_LOCKED    = 8'h00;
   localparam logic [7:0]  LOCK_RST       = 8'h00;
   localparam logic [3:0]  REG_PSC        = 4'h0;
   localparam logic [3:0]  REG_RSS        = 4'h1;
   localparam logic [3:0]  REG_LOCK       = 4'h2;
   localparam int          PROGRAM_WRITE_ENABLE_BIT       = 0;
   localparam int          PROGRAM_ERASE_ENABLE_BIT       = 1;
   localparam int          RSS_POR_BIT    = 0;
   localparam int          RSS_FERR_BIT   = 6;
   localparam logic        POR_RST        = 1'b1;
   localparam logic [7:0]  RDATA_RST      = 8'h00;

   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE, OP_FULL_ERASE} fsg_op_e;
   typedef enum logic [1:0] {V_PERMIT, V_REFUSE, V_FLASH_ERROR_RESET} fsg_verdict_e;
endpackage

// ### fsg_lock_store.sv
// Holder of the lock byte that is in force, and of its written state.
`timescale 1ns/1ps
module fsg_lock_store
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] lock_byte_flash,
   input  wire logic       reload,
   input  wire logic       full_erase,
   input  wire logic       lock_write,
   output logic [7:0]      active_lock,
   output logic            lock_written
);
   import fsg_pkg::*;

   logic load_pending_reg;

   // The stored byte is taken in at the first edge after a reset and again on each reload.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         load_pending_reg <= 1'b1;
      else
         load_pending_reg <= 1'b0;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         active_lock <= LOCK_RST;
      else if (full_erase)
         active_lock <= ERASED_BYTE;
      else if (load_pending_reg || reload)
         active_lock <= lock_byte_flash;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         lock_written <= 1'b1;
      else if (full_erase)
         lock_written <= 1'b0;
      else if (lock_write)
         lock_written <= 1'b1;
      else if (load_pending_reg || reload)
         lock_written <= (lock_byte_flash != ERASED_BYTE);
   end
endmodule // fsg_lock_store

// ### fsg_guard.sv
// Access checker for the program flash: permits, refuses or resets.
// Operation
// - Unlocked ordinary pages open to every source.
// - Locked pages: debug refused, unlocked firmware resets.
// - Lock page read/write open until something locked.
// - Lock byte read follows the same locking rule.
// - Lock page erase: debug only, firmware resets.
// - Locked lock page erased only by full erase.
// - Changing lock byte bits: debug refused, firmware resets.
// - Reserved area: debug refused, firmware resets.
// - Error reset leaves flash error flag set.
// - Debug violations are dropped, never reset.
// - Any locked page also locks lock page.
// - Written lock byte frozen until full erase; debug lock page erase is still permitted until a reset puts the byte in force.
// - Firmware lock write applies after next reset.
// - Firmware modify without supply monitor resets.
// - Interrupts held pending during write or erase.
// - Write enable is bit zero of control.
// - Locked pages counted from zero, complement value.
// - Lock byte is last user flash byte.
// - 0x7C00 to 0x7FFF is reserved area.
// - Modify needs write enable, erase also erase enable.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module fsg_guard
(
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       req_valid,
   input  wire logic                       req_from_debug,
   input  wire fsg_pkg::fsg_op_e           req_op,
   input  wire logic [fsg_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [fsg_pkg::ADDR_W-1:0] req_fetch_addr,
   input  wire logic                       supply_mon_on,
   input  wire logic                       flash_done,
   input  wire logic [7:0]                 lock_byte_flash,
   input  wire logic [3:0]                 reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic [7:0]                      reg_rdata,
   output logic                            resp_permit,
   output logic                            resp_refuse,
   output logic                            flash_error_reset,
   output logic                            irq_hold
);
   import fsg_pkg::*;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   fsg_verdict_e      verdict;
   fsg_verdict_e      deny;
   logic [7:0]        active_lock;
   logic              lock_written;
   logic              any_locked;
   logic              fw_locked;
   logic              tgt_locked;
   logic              tgt_rsv;
   logic              tgt_lock_page;
   logic              tgt_lock_byte;
   logic              modify;
   logic              permit_reg;
   logic              refuse_reg;
   logic              flash_error_reset_reg;
   logic              busy_reg;
   logic              program_write_enable_reg;
   logic              program_erase_enable_reg;
   logic              mon_rst_en_reg;
   logic              por_flag_reg;
   logic              ferr_flag_reg;
   logic [7:0]        rdata_reg;
   logic [7:0]        rdata_next;
   logic              full_erase_ok;
   logic              lock_write_ok;

   // A page is locked when below the complement count, or when it holds the lock byte and anything is locked.
   function automatic logic page_locked(input logic [PAGE_W-1:0] pg, input logic [7:0] lb);
      logic [7:0] n;
      n = ~lb;
      page_locked = ({3'h0, pg} < n) || ((pg == LOCK_PAGE) && (n != NONE_LOCKED));
   endfunction

   fsg_lock_store u_lock
   (
      .core_clk        (core_clk),
      .sys_rst         (sys_rst),
      .lock_byte_flash (lock_byte_flash),
      .reload          (flash_error_reset_reg),
      .full_erase      (full_erase_ok),
      .lock_write      (lock_write_ok),
      .active_lock     (active_lock),
      .lock_written    (lock_written)
   );

   assign any_locked    = (active_lock != ERASED_BYTE);
   assign fw_locked     = page_locked(req_fetch_addr[ADDR_W-1:PAGE_BITS], active_lock);
   assign tgt_locked    = page_locked(req_addr[ADDR_W-1:PAGE_BITS], active_lock);
   assign tgt_rsv       = (req_addr >= RSV_LO) && (req_addr <= RSV_HI);
   assign tgt_lock_page = (req_addr[ADDR_W-1:PAGE_BITS] == LOCK_PAGE);
   assign tgt_lock_byte = (req_addr == LOCK_BYTE_ADDR);
   assign modify        = (req_op != OP_READ);
   assign deny          = req_from_debug ? V_REFUSE : V_FLASH_ERROR_RESET;

   // Checks run in priority order; the first match decides.
   always_comb
   begin
      verdict = V_PERMIT;
      if (!req_from_debug && (req_op == OP_FULL_ERASE))
         verdict = V_FLASH_ERROR_RESET;
      else if (!req_from_debug && modify && !program_write_enable_reg)
         verdict = V_REFUSE;
      else if (!req_from_debug && (req_op == OP_ERASE) && !program_erase_enable_reg)
         verdict = V_REFUSE;
      else if (!req_from_debug && modify && !(supply_mon_on && mon_rst_en_reg))
         verdict = V_FLASH_ERROR_RESET;
      else if (req_from_debug && (req_op == OP_FULL_ERASE))
         verdict = V_PERMIT;
      else if (tgt_rsv)
         verdict = deny;
      else if (tgt_lock_page && (req_op == OP_ERASE))
         verdict = (req_from_debug && !any_locked) ? V_PERMIT : deny;
      else if (tgt_lock_byte && (req_op == OP_WRITE) && lock_written)
         verdict = deny;
      else if (tgt_locked && !req_from_debug && fw_locked)
         verdict = V_PERMIT;
      else if (tgt_locked)
         verdict = deny;
   end

   assign full_erase_ok = req_valid && (verdict == V_PERMIT) && (req_op == OP_FULL_ERASE);
   assign lock_write_ok = req_valid && (verdict == V_PERMIT) && (req_op == OP_WRITE) && tgt_lock_byte;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         permit_reg <= 1'b0;
         refuse_reg <= 1'b0;
         flash_error_reset_reg   <= 1'b0;
      end
      else
      begin
         permit_reg <= req_valid && (verdict == V_PERMIT);
         refuse_reg <= req_valid && (verdict == V_REFUSE);
         flash_error_reset_reg   <= req_valid && (verdict == V_FLASH_ERROR_RESET);
      end
   end

   assign resp_permit       = permit_reg;
   assign resp_refuse       = refuse_reg;
   assign flash_error_reset = flash_error_reset_reg;

   // Interrupt service waits while a permitted write or erase is in the array.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         busy_reg <= 1'b0;
      else if (req_valid && (verdict == V_PERMIT) && modify)
         busy_reg <= 1'b1;
      else if (flash_done || flash_error_reset_reg)
         busy_reg <= 1'b0;
   end

   assign irq_hold = busy_reg;

   // The error reset is a device reset, so the enables fall back to zero.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         program_write_enable_reg <= 1'b0;
         program_erase_enable_reg <= 1'b0;
      end
      else if (flash_error_reset_reg)
      begin
         program_write_enable_reg <= 1'b0;
         program_erase_enable_reg <= 1'b0;
      end
      else if (reg_wr && (reg_addr == REG_PSC))
      begin
         program_write_enable_reg <= reg_wdata[PROGRAM_WRITE_ENABLE_BIT];
         program_erase_enable_reg <= reg_wdata[PROGRAM_ERASE_ENABLE_BIT];
      end
   end

   // Writing the power-on flag position enables the supply monitor as a reset source.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         mon_rst_en_reg <= 1'b0;
      else if (reg_wr && (reg_addr == REG_RSS))
         mon_rst_en_reg <= reg_wdata[RSS_POR_BIT];
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         por_flag_reg  <= POR_RST;
         ferr_flag_reg <= 1'b0;
      end
      else if (flash_error_reset_reg)
      begin
         por_flag_reg  <= 1'b0;
         ferr_flag_reg <= 1'b1;
      end
   end

   always_comb
   begin
      rdata_next = RDATA_RST;
      if (reg_rd)
      begin
         unique case (reg_addr)
            REG_PSC:
               rdata_next = {6'h00, program_erase_enable_reg, program_write_enable_reg};
            REG_RSS:
            begin
               rdata_next[RSS_FERR_BIT] = ferr_flag_reg;
               rdata_next[RSS_POR_BIT]  = por_flag_reg;
            end
            REG_LOCK:
               rdata_next = active_lock;
            default:
               rdata_next = RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_reg <= RDATA_RST;
      else
         rdata_reg <= rdata_next;
   end

   assign reg_rdata = rdata_reg;

   debug_no_reset_a: assert property (req_valid && req_from_debug |=> !flash_error_reset)
      else $error("debug request caused an error reset");

   rsv_fw_reset_a: assert property (req_valid && !req_from_debug && tgt_rsv && (req_op == OP_READ)
                                    |=> flash_error_reset && !resp_permit)
      else $error("firmware reserved read did not reset");

   rsv_dbg_refuse_a: assert property (req_valid && req_from_debug && tgt_rsv && (req_op != OP_FULL_ERASE)
                                      |=> resp_refuse)
      else $error("debug reserved access not refused");

   open_page_a: assert property (req_valid && (req_op == OP_READ) && !tgt_locked && !tgt_rsv
                                 |=> resp_permit)
      else $error("unlocked page read not permitted");

   locked_fw_a: assert property (req_valid && !req_from_debug && (req_op == OP_READ) && tgt_locked
                                 && !tgt_rsv && !fw_locked |=> flash_error_reset)
      else $error("unlocked firmware read of locked page did not reset");

   lock_page_dbg_a: assert property (req_valid && req_from_debug && any_locked && tgt_lock_page
                                     && (req_op == OP_READ) |=> resp_refuse)
      else $error("debug read of locked lock page not refused");

   error_flag_a: assert property (flash_error_reset |=> ferr_flag_reg && !por_flag_reg && !program_write_enable_reg)
      else $error("error reset did not leave the flag set");

   supply_gate_a: assert property (req_valid && !req_from_debug && (req_op == OP_WRITE) && program_write_enable_reg
                                   && !(supply_mon_on && mon_rst_en_reg) |=> flash_error_reset)
      else $error("write without supply monitor did not reset");

   lock_defer_a: assert property (lock_write_ok |=> $stable(active_lock) [*2])
      else $error("lock write took effect before reset");

   lock_frozen_a: assert property (req_valid && lock_written && tgt_lock_byte && (req_op == OP_WRITE)
                                   |=> !resp_permit)
      else $error("frozen lock byte was changed");

   write_bit_a: assert property (reg_wr && (reg_addr == REG_PSC) && !flash_error_reset
                                 |=> program_write_enable_reg == $past(reg_wdata[PROGRAM_WRITE_ENABLE_BIT]))
      else $error("write enable not at bit zero");

   erase_gate_a: assert property (req_valid && !req_from_debug && (req_op == OP_ERASE) && !program_erase_enable_reg
                                  |=> resp_refuse)
      else $error("erase without erase enable not refused");

   busy_hold_a: assert property (req_valid && (verdict == V_PERMIT) && modify |=> irq_hold)
      else $error("interrupts not held during flash operation");

   lock_byte_fw_a: assert property (req_valid && !req_from_debug && tgt_lock_byte && (req_op == OP_READ)
                                    && fw_locked |=> resp_permit)
      else $error("locked firmware could not read the lock byte");

   lock_erase_fw_a: assert property (req_valid && !req_from_debug && tgt_lock_page && (req_op == OP_ERASE)
                                     && program_write_enable_reg && program_erase_enable_reg && supply_mon_on && mon_rst_en_reg |=> flash_error_reset)
      else $error("firmware erase of lock page did not reset");

   lock_erase_dbg_a: assert property (req_valid && req_from_debug && !any_locked && tgt_lock_page
                                      && (req_op == OP_ERASE) |=> resp_permit)
      else $error("debug erase of open lock page not permitted");

   full_erase_a: assert property (req_valid && req_from_debug && (req_op == OP_FULL_ERASE)
                                  |=> resp_permit && (active_lock == ERASED_BYTE) && !lock_written)
      else $error("debug full erase did not unlock everything");

   fw_full_erase_a: assert property (req_valid && !req_from_debug && (req_op == OP_FULL_ERASE)
                                     |=> flash_error_reset)
      else $error("firmware full erase did not reset");

   lock_byte_dbg_a: assert property (req_valid && req_from_debug && lock_written && tgt_lock_byte
                                     && (req_op == OP_WRITE) |=> resp_refuse)
      else $error("debug change of lock byte not refused");

   lock_page_fw_a: assert property (req_valid && !req_from_debug && any_locked && tgt_lock_page
                                    && !fw_locked && (req_op == OP_READ) |=> flash_error_reset)
      else $error("lock page not locked while other pages are");

   lock_count_a: assert property (req_valid && req_from_debug && (req_op == OP_READ) && !tgt_rsv
                                  && !tgt_lock_page && ({3'h0, req_addr} < {~active_lock, 10'h000}) |=> resp_refuse)
      else $error("page below the locked count not refused");

   fetch_page_a: assert property (req_valid && !req_from_debug && (req_op == OP_READ) && tgt_locked
                                  && fw_locked && !tgt_rsv |=> resp_permit)
      else $error("firmware on a locked page was not trusted");

   write_gate_a: assert property (req_valid && !req_from_debug && (req_op == OP_WRITE) && !program_write_enable_reg
                                  |=> resp_refuse)
      else $error("write without write enable not refused");

   lock_reload_a: assert property (flash_error_reset && !full_erase_ok
                                   |=> active_lock == $past(lock_byte_flash))
      else $error("error reset did not apply the stored lock byte");

   busy_clear_a: assert property (flash_done && !(req_valid && (verdict == V_PERMIT) && modify)
                                  |=> !irq_hold)
      else $error("interrupt hold not released after flash operation");

   ctrl_read_a: assert property (reg_rd && (reg_addr == REG_PSC)
                                 |=> reg_rdata[PROGRAM_WRITE_ENABLE_BIT] == $past(program_write_enable_reg))
      else $error("write enable not read back at bit zero");
endmodule // fsg_guard

// ### fsg_flash_model.sv
// Behavioural program flash array beside the guard: lock byte storage and end of operations.
`timescale 1ns/1ps
module fsg_flash_model
#(
   parameter int         DONE_DLY  = 4,
   parameter logic [7:0] INIT_LOCK = 8'hFD
)
(
   input  wire logic             core_clk,
   input  wire logic             req_valid,
   input  wire fsg_pkg::fsg_op_e req_op,
   input  wire logic [14:0]      req_addr,
   input  wire logic             resp_permit,
   input  wire logic [7:0]       prog_value,
   output logic [7:0]            lock_byte_flash,
   output logic                  flash_done
);
   import fsg_pkg::*;
   fsg_op_e     op_q;
   logic [14:0] addr_q;
   int          cnt;
   initial
   begin
      lock_byte_flash = INIT_LOCK;
      flash_done = 1'b0;
      cnt = 0;
   end
   // A flash write only clears bits, so the stored byte is ANDed with the programmed value.
   always @(posedge core_clk)
   begin
      flash_done <= 1'b0;
      if (req_valid)
      begin
         op_q   <= req_op;
         addr_q <= req_addr;
      end
      if (resp_permit && op_q != OP_READ)
      begin
         cnt <= DONE_DLY;
         if (op_q == OP_FULL_ERASE || (op_q == OP_ERASE && addr_q[14:10] == LOCK_PAGE))
            lock_byte_flash <= ERASED_BYTE;
         else if (op_q == OP_WRITE && addr_q == LOCK_BYTE_ADDR)
            lock_byte_flash <= lock_byte_flash & prog_value;
      end
      else if (cnt == 1)
      begin
         flash_done <= 1'b1;
         cnt <= 0;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule // fsg_flash_model

// ### test_fsg_guard.sv
// Self-checking testbench of the flash security access guard.
`timescale 1ns/1ps
module test_fsg_guard;
   import fsg_pkg::*;
   typedef struct packed
   {
      logic        dbg;
      fsg_op_e     op;
      logic [14:0] addr;
      logic [14:0] fetch;
      logic [1:0]  psc;
      logic        mon;
      logic        rse;
      logic [2:0]  exp;
   } fsg_row_s;
   localparam logic [2:0]  P = 3'b100;
   localparam logic [2:0]  R = 3'b010;
   localparam logic [2:0]  F = 3'b001;
   localparam logic [14:0] L = 15'h0100;
   localparam logic [14:0] U = 15'h1000;
   logic        core_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_from_debug = 1'b0;
   logic        supply_mon_on = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   fsg_op_e     req_op = OP_READ;
   logic [14:0] req_addr = 15'h0000, req_fetch_addr = 15'h0000;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00, prog_value = 8'hFF, reg_rdata, lock_byte_flash;
   logic        resp_permit, resp_refuse, flash_error_reset, irq_hold, flash_done;
   int          num_errors = 0, compares = 0, cycles = 0;
   fsg_row_s    rows [24];

   fsg_guard dut (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_from_debug(req_from_debug),
      .req_op(req_op), .req_addr(req_addr), .req_fetch_addr(req_fetch_addr), .supply_mon_on(supply_mon_on),
      .flash_done(flash_done), .lock_byte_flash(lock_byte_flash), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .resp_permit(resp_permit),
      .resp_refuse(resp_refuse), .flash_error_reset(flash_error_reset), .irq_hold(irq_hold));
   fsg_flash_model flash (.core_clk(core_clk), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
      .resp_permit(resp_permit), .prog_value(prog_value), .lock_byte_flash(lock_byte_flash), .flash_done(flash_done));

   always #25 core_clk = ~core_clk;

   task automatic final_report();
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         num_errors++;
         $display("wrong value at %0t ns: run did not finish", $time);
         final_report();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      check(reg_rdata, exp, "register");
   endtask

   task automatic access(input fsg_row_s r);
      reg_write(REG_PSC, {6'h00, r.psc});
      reg_write(REG_RSS, {7'h00, r.rse});
      @(posedge core_clk);
      supply_mon_on  <= r.mon;
      req_valid      <= 1'b1;
      req_from_debug <= r.dbg;
      req_op         <= r.op;
      req_addr       <= r.addr;
      req_fetch_addr <= r.fetch;
      @(posedge core_clk);
      req_valid      <= 1'b0;
      #1;
      check({5'h00, resp_permit, resp_refuse, flash_error_reset}, {5'h00, r.exp}, "verdict");
      if (r.exp == P && r.op != OP_READ)
         check({7'h00, irq_hold}, 8'h01, "hold");
   endtask

   initial
   begin
      rows = '{'{1, OP_READ, 15'h1000, U, 3, 1, 1, P}, '{0, OP_WRITE, 15'h1000, U, 1, 1, 1, P},
               '{0, OP_ERASE, 15'h1000, L, 3, 1, 1, P}, '{1, OP_READ, 15'h0400, U, 3, 1, 1, R},
               '{0, OP_READ, 15'h0400, U, 3, 1, 1, F}, '{0, OP_READ, 15'h07FF, L, 3, 1, 1, P},
               '{1, OP_WRITE, 15'h0800, U, 1, 1, 1, P}, '{1, OP_WRITE, 15'h7800, U, 1, 1, 1, R},
               '{0, OP_READ, 15'h7A00, U, 3, 1, 1, F}, '{0, OP_WRITE, 15'h7800, L, 1, 1, 1, P},
               '{1, OP_READ, 15'h7BFF, U, 3, 1, 1, R}, '{0, OP_READ, 15'h7BFF, L, 3, 1, 1, P},
               '{0, OP_ERASE, 15'h7800, L, 3, 1, 1, F}, '{1, OP_ERASE, 15'h7800, U, 3, 1, 1, R},
               '{0, OP_WRITE, 15'h7BFF, L, 1, 1, 1, F}, '{1, OP_WRITE, 15'h7BFF, U, 1, 1, 1, R},
               '{1, OP_READ, 15'h7C00, U, 3, 1, 1, R}, '{0, OP_READ, 15'h7FFF, L, 3, 1, 1, F},
               '{0, OP_WRITE, 15'h7C00, U, 1, 1, 1, F}, '{0, OP_WRITE, 15'h1000, U, 0, 1, 1, R},
               '{0, OP_ERASE, 15'h1000, U, 1, 1, 1, R}, '{0, OP_WRITE, 15'h1000, U, 1, 0, 1, F},
               '{0, OP_WRITE, 15'h1000, U, 1, 1, 0, F}, '{0, OP_FULL_ERASE, 15'h0000, L, 3, 1, 1, F}};
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      foreach (rows[i])
         access(rows[i]);
      reg_check(REG_RSS, 8'h40);
      reg_check(REG_PSC, 8'h00);
      reg_check(REG_LOCK, 8'hFD);
      reg_check(4'hF, 8'h00);
      access('{1, OP_FULL_ERASE, 15'h0000, U, 0, 1, 1, P});
      reg_check(REG_LOCK, 8'hFF);
      access('{1, OP_ERASE, 15'h7800, U, 0, 1, 1, P});
      access('{0, OP_ERASE, 15'h7A00, U, 3, 1, 1, F});
      prog_value <= 8'hFE;
      access('{0, OP_WRITE, 15'h7BFF, U, 1, 1, 1, P});
      reg_check(REG_LOCK, 8'hFF);
      for (int k = 0; k < 10 && irq_hold !== 1'b0; k++)
         @(posedge core_clk);
      #1;
      check({7'h00, irq_hold}, 8'h00, "hold");
      access('{1, OP_WRITE, 15'h7BFF, U, 0, 1, 1, R});
      access('{0, OP_WRITE, 15'h7BFF, U, 1, 1, 1, F});
      reg_check(REG_LOCK, 8'hFE);
      access('{1, OP_READ, 15'h03FF, U, 3, 1, 1, R});
      access('{1, OP_READ, 15'h0400, U, 3, 1, 1, P});
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      reg_check(REG_RSS, 8'h01);
      reg_check(REG_PSC, 8'h00);
      reg_check(REG_LOCK, 8'hFE);
      final_report();
   end
endmodule // test_fsg_guard
